// ===== design/rpj_readback.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] eight 128-bit pages, whole page per read
// [R2] core reads pages during normal operation
// [R3] page address from TDI or core logic
// [R4] parallel page load, serial TCK-synchronous output
// [R5] shift only in user DR shift state
// [R6] capture, shift, update indicators pace serializer
// [R7] SRAM init words arrive serially through TAP
// [R8] tester repeats SRAM init after power-up
// [R9] tester keeps TCK at most 20 MHz
// [R10] capture loads page, update latches address
// [R11] least significant page bit leaves first
module rpj_readback #(
    parameter bit ADDR_FROM_TDI = 1'b1,
    parameter logic [rpj_pkg::PAGE_COUNT*rpj_pkg::PAGE_BITS-1:0]
        PAGE_INIT = '0,
    parameter int FIFO_DEPTH = rpj_pkg::FIFO_DEPTH
) (
    // core clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // user tap tile, link clock domain
    input wire logic tck,
    input wire logic tap_rst_n,
    input wire logic user_dr_capture_state,
    input wire logic user_dr_shift_state,
    input wire logic user_dr_update_state,
    input wire logic tdi,
    output logic tdo,
    // core page read
    input wire logic [rpj_pkg::PAGE_AW-1:0] core_rd_addr,
    output logic [rpj_pkg::PAGE_BITS-1:0] core_rd_data,
    // core address generator
    input wire logic addr_step,
    output logic [rpj_pkg::PAGE_AW-1:0] core_page_addr,
    // sram initialisation port
    output logic sram_wr_valid,
    input wire logic sram_wr_ready,
    output logic [rpj_pkg::SRAM_AW-1:0] sram_wr_addr,
    output logic [rpj_pkg::SRAM_DW-1:0] sram_wr_data
);
    typedef struct packed {
        logic [rpj_pkg::PAGE_BITS-1:0] shreg;
        logic [rpj_pkg::PAGE_AW-1:0] page_addr;
        logic [rpj_pkg::PAGE_AW-1:0] gray_s1;
        logic [rpj_pkg::PAGE_AW-1:0] gray_s2;
        logic [rpj_pkg::SRAM_WW-1:0] hold;
        logic req_tgl;
        logic ack_s1;
        logic ack_s2;
    } rpj_tck_state_type;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_s3;
        rpj_pkg::rpj_hs_type hs;
        logic ack_tgl;
        logic [rpj_pkg::PAGE_AW-1:0] addr_bin;
        logic [rpj_pkg::PAGE_AW-1:0] addr_gray;
        logic [rpj_pkg::PAGE_BITS-1:0] rd_data;
    } rpj_core_state_type;

    rpj_tck_state_type t_reg;
    rpj_tck_state_type t_next;
    rpj_core_state_type m_reg;
    rpj_core_state_type m_next;

    rpj_stream_if #(.W(rpj_pkg::SRAM_WW)) fill_if ();
    rpj_stream_if #(.W(rpj_pkg::SRAM_WW)) drain_if ();

    logic busy;
    logic req_edge;
    logic push;
    logic [3:0] dr_op;
    logic [rpj_pkg::PAGE_AW-1:0] dr_addr;
    logic out_next_bit;

    // page store is read without a clock, from either domain
    // [R1] page slice select
    function automatic logic [rpj_pkg::PAGE_BITS-1:0] page_word(
        input logic [rpj_pkg::PAGE_AW-1:0] a
    );
        page_word = PAGE_INIT[a*rpj_pkg::PAGE_BITS +: rpj_pkg::PAGE_BITS];
    endfunction

    function automatic logic [rpj_pkg::PAGE_AW-1:0] gray2bin(
        input logic [rpj_pkg::PAGE_AW-1:0] g
    );
        logic [rpj_pkg::PAGE_AW-1:0] b;
        b[rpj_pkg::PAGE_AW-1] = g[rpj_pkg::PAGE_AW-1];
        for (int i = rpj_pkg::PAGE_AW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        gray2bin = b;
    endfunction

    assign dr_op = t_reg.shreg[rpj_pkg::OP_MSB:rpj_pkg::OP_LSB];
    assign dr_addr = t_reg.shreg[rpj_pkg::PAGE_ADDR_LSB +: rpj_pkg::PAGE_AW];
    assign busy = (t_reg.req_tgl != t_reg.ack_s2);
    assign out_next_bit = t_reg.shreg[1];

    // [R4] serial output straight from the shift flop
    assign tdo = t_reg.shreg[0];

    // link side: serializer and frame decode
    always_comb begin
        t_next = t_reg;
        t_next.ack_s1 = m_reg.ack_tgl;
        t_next.ack_s2 = t_reg.ack_s1;
        t_next.gray_s1 = m_reg.addr_gray;
        t_next.gray_s2 = t_reg.gray_s1;
        // [R3] address from core counter
        if (!ADDR_FROM_TDI) begin
            t_next.page_addr = gray2bin(t_reg.gray_s2);
        end
        // [R6] capture outranks shift
        if (user_dr_capture_state) begin
            // [R10] parallel page load
            t_next.shreg = page_word(t_reg.page_addr);
        end else if (user_dr_shift_state) begin
            // [R11] lsb out, tdi in at top
            t_next.shreg = {tdi, t_reg.shreg[rpj_pkg::PAGE_BITS-1:1]};
        end
        // [R10] update latches address
        if (user_dr_update_state) begin
            if (dr_op == rpj_pkg::OP_PAGE_ADDR && ADDR_FROM_TDI) begin
                t_next.page_addr = dr_addr;
            end else if (dr_op == rpj_pkg::OP_SRAM_WR && !busy) begin
                // [R7] sram word handed over
                t_next.hold = t_reg.shreg[rpj_pkg::SRAM_WW-1:0];
                t_next.req_tgl = !t_reg.req_tgl;
            end
        end
    end

    always_ff @(posedge tck or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            t_reg.shreg <= rpj_pkg::DR_RESET;
            t_reg.page_addr <= rpj_pkg::ADDR_RESET;
            t_reg.gray_s1 <= rpj_pkg::ADDR_RESET;
            t_reg.gray_s2 <= rpj_pkg::ADDR_RESET;
            t_reg.hold <= '0;
            t_reg.req_tgl <= 1'b0;
            t_reg.ack_s1 <= 1'b0;
            t_reg.ack_s2 <= 1'b0;
        end else begin
            t_reg <= t_next;
        end
    end

    // core side: address counter, page read, sram word intake
    assign req_edge = (m_reg.req_s2 != m_reg.req_s3);
    assign fill_if.valid = push;
    // hold is stable while the toggle request is outstanding
    assign fill_if.data = t_reg.hold;

    always_comb begin
        m_next = m_reg;
        push = 1'b0;
        m_next.req_s1 = t_reg.req_tgl;
        m_next.req_s2 = m_reg.req_s1;
        m_next.req_s3 = m_reg.req_s2;
        // [R2] core page read
        m_next.rd_data = page_word(core_rd_addr);
        // [R3] core address generator
        if (addr_step) begin
            m_next.addr_bin = m_reg.addr_bin + 1'b1;
        end
        m_next.addr_gray = m_next.addr_bin ^ (m_next.addr_bin >> 1);
        // [R7] accept word when buffer has room
        unique case (m_reg.hs)
            rpj_pkg::HS_IDLE: begin
                if (req_edge) begin
                    if (fill_if.ready) begin
                        push = 1'b1;
                        m_next.ack_tgl = !m_reg.ack_tgl;
                    end else begin
                        m_next.hs = rpj_pkg::HS_WAIT;
                    end
                end
            end
            rpj_pkg::HS_WAIT: begin
                if (fill_if.ready) begin
                    push = 1'b1;
                    m_next.ack_tgl = !m_reg.ack_tgl;
                    m_next.hs = rpj_pkg::HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            m_reg.req_s1 <= 1'b0;
            m_reg.req_s2 <= 1'b0;
            m_reg.req_s3 <= 1'b0;
            m_reg.hs <= rpj_pkg::HS_IDLE;
            m_reg.ack_tgl <= 1'b0;
            m_reg.addr_bin <= rpj_pkg::ADDR_RESET;
            m_reg.addr_gray <= rpj_pkg::ADDR_RESET;
            m_reg.rd_data <= rpj_pkg::DR_RESET;
        end else begin
            m_reg <= m_next;
        end
    end

    assign core_rd_data = m_reg.rd_data;
    assign core_page_addr = m_reg.addr_bin;

    // [R7] sram words buffered toward the core
    rpj_fifo #(
        .W(rpj_pkg::SRAM_WW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst_n(rst_n),
        .wr_s(fill_if.sink),
        .rd_s(drain_if.source)
    );

    assign sram_wr_valid = drain_if.valid;
    assign drain_if.ready = sram_wr_ready;
    assign sram_wr_addr =
        drain_if.data[rpj_pkg::SRAM_ADDR_LSB +: rpj_pkg::SRAM_AW];
    assign sram_wr_data =
        drain_if.data[rpj_pkg::SRAM_DATA_LSB +: rpj_pkg::SRAM_DW];

    sequence seq_cap;
        user_dr_capture_state;
    endsequence

    sequence seq_shift;
        user_dr_shift_state && !user_dr_capture_state;
    endsequence

    sequence seq_idle;
        !user_dr_shift_state && !user_dr_capture_state;
    endsequence

    sequence seq_addr_upd;
        user_dr_update_state && dr_op == rpj_pkg::OP_PAGE_ADDR;
    endsequence

    sequence seq_sram_upd;
        user_dr_update_state && dr_op == rpj_pkg::OP_SRAM_WR && !busy;
    endsequence

    AST_CAP_LOAD: assert property ( // [R10]
        @(posedge tck) disable iff (!tap_rst_n)
        seq_cap |=> t_reg.shreg == page_word($past(t_reg.page_addr)))
        else $error("capture did not load the addressed page");

    AST_SHIFT_LSB: assert property ( // [R11]
        @(posedge tck) disable iff (!tap_rst_n)
        seq_shift |=> tdo == $past(out_next_bit))
        else $error("shift did not advance output by one bit");

    AST_SHIFT_IN: assert property ( // [R4]
        @(posedge tck) disable iff (!tap_rst_n)
        seq_shift |=> t_reg.shreg[rpj_pkg::PAGE_BITS-1] == $past(tdi))
        else $error("tdi bit not entered at the top");

    AST_HOLD: assert property ( // [R5]
        @(posedge tck) disable iff (!tap_rst_n)
        seq_idle |=> $stable(t_reg.shreg))
        else $error("shift register moved outside shift state");

    AST_ADDR_UPD: assert property ( // [R3]
        @(posedge tck) disable iff (!tap_rst_n)
        seq_addr_upd ##0 ADDR_FROM_TDI |=>
            t_reg.page_addr == $past(dr_addr))
        else $error("update did not latch page address");

    AST_SRAM_REQ: assert property ( // [R7]
        @(posedge tck) disable iff (!tap_rst_n)
        seq_sram_upd |=> busy ##1 busy)
        else $error("sram word not handed to core side");

    AST_CORE_RD: assert property ( // [R2]
        @(posedge mclk) disable iff (!rst_n)
        1'b1 |=> core_rd_data == page_word($past(core_rd_addr)))
        else $error("core page read returned wrong data");

    AST_ADDR_STEP: assert property ( // [R3]
        @(posedge mclk) disable iff (!rst_n)
        addr_step |=> core_page_addr ==
            rpj_pkg::PAGE_AW'($past(core_page_addr) + 1'b1))
        else $error("address generator did not step by one");

    AST_PUSH_ACK: assert property ( // [R7]
        @(posedge mclk) disable iff (!rst_n)
        push |=> m_reg.ack_tgl != $past(m_reg.ack_tgl)
            ##1 !push)
        else $error("accepted sram word not acknowledged once");
endmodule

// ===== shared/rpj_pkg.sv
package rpj_pkg;
    // page store geometry
    localparam int PAGE_COUNT = 8;
    localparam int PAGE_BITS = 128;
    localparam int PAGE_AW = 3;
    localparam int PAGE_ADDR_LSB = 0;
    // command field of a shifted-in frame
    localparam int OP_MSB = 127;
    localparam int OP_LSB = 124;
    localparam logic [3:0] OP_PAGE_ADDR = 4'h1;
    localparam logic [3:0] OP_SRAM_WR = 4'h2;
    // sram initialisation word within a frame
    localparam int SRAM_DW = 32;
    localparam int SRAM_AW = 10;
    localparam int SRAM_DATA_LSB = 0;
    localparam int SRAM_ADDR_LSB = 32;
    localparam int SRAM_WW = SRAM_AW + SRAM_DW;
    localparam int FIFO_DEPTH = 8;
    // reset values
    localparam logic [PAGE_BITS-1:0] DR_RESET = 128'h0;
    localparam logic [PAGE_AW-1:0] ADDR_RESET = 3'h0;
    // link clock limits of the external programmer, core clock rate
    localparam int TCK_MAX_HZ = 20_000_000;
    localparam int TCK_DEFAULT_HZ = 4_000_000;
    localparam int MCLK_HZ = 25_000_000;
    // core side handshake states
    typedef enum logic {HS_IDLE, HS_WAIT} rpj_hs_type;
endpackage

// ===== shared/rpj_stream_if.sv
`timescale 1ns/1ps
interface rpj_stream_if #(parameter int W = 8) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// ===== design/rpj_fifo.sv
`timescale 1ns/1ps
module rpj_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill and drain sides
    rpj_stream_if.sink wr_s,
    rpj_stream_if.source rd_s
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } rpj_fifo_state_type;

    rpj_fifo_state_type st_reg;
    rpj_fifo_state_type st_next;
    logic full;
    logic empty;
    logic [AW:0] fill;

    assign empty = (st_reg.wr_ptr == st_reg.rd_ptr);
    assign full = (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW]) &&
        (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]);
    assign fill = st_reg.wr_ptr - st_reg.rd_ptr;
    assign wr_s.ready = !full;
    assign rd_s.valid = !empty;
    assign rd_s.data = st_reg.mem[st_reg.rd_ptr[AW-1:0]];

    always_comb begin
        st_next = st_reg;
        if (wr_s.valid && !full) begin
            st_next.mem[st_reg.wr_ptr[AW-1:0]] = wr_s.data;
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        end
        if (rd_s.ready && !empty) begin
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // a full buffer refuses the word and keeps its write pointer
    AST_FIFO_FULL_HOLD: assert property ( // [R7]
        @(posedge clk) disable iff (!rst_n)
        full && wr_s.valid |=> $stable(st_reg.wr_ptr))
        else $error("fifo accepted a word while full");

    AST_FIFO_FILL_BOUND: assert property ( // [R7]
        @(posedge clk) disable iff (!rst_n)
        fill <= (AW+1)'(DEPTH))
        else $error("fifo fill level above depth");
endmodule

// ===== tb/rpj_tester.sv
`timescale 1ns/1ps
module rpj_tester (
    // tap tile indicators and link clock
    output logic tck,
    output logic tap_rst_n,
    output logic cap,
    output logic shift,
    output logic upd,
    output logic tdi,
    // serial return from the serializer
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tap_rst_n = 1'b0;
        cap = 1'b0;
        shift = 1'b0;
        upd = 1'b0;
        tdi = 1'b0;
    end

    // 64 ns link period, stands low between frames
    task automatic pulse(input int n);
        for (int i = 0; i < n; i++) begin
            #32 tck = 1'b1;
            #32 tck = 1'b0;
        end
    endtask

    task automatic reset_tap();
        tap_rst_n = 1'b0;
        pulse(3);
        tap_rst_n = 1'b1;
    endtask

    // capture, idle gap, 128 shifts, update
    task automatic frame(input logic [127:0] din, input int gap,
                         output logic [127:0] dout);
        cap = 1'b1;
        pulse(1);
        cap = 1'b0;
        pulse(gap);
        shift = 1'b1;
        for (int i = 0; i < 128; i++) begin
            tdi = din[i];
            #32 dout[i] = tdo;
            tck = 1'b1;
            #32 tck = 1'b0;
        end
        shift = 1'b0;
        upd = 1'b1;
        pulse(1);
        upd = 1'b0;
        // released line shows the inverse of its last bit
        tdi = ~tdi;
    endtask
endmodule

// ===== tb/test_rom_page_jtag_readback.sv
`timescale 1ns/1ps
module test_rom_page_jtag_readback;
    localparam int PB = rpj_pkg::PAGE_BITS;
    localparam int WW = rpj_pkg::SRAM_WW;
    function automatic logic [8*PB-1:0] mk_init();
        logic [8*PB-1:0] v;
        for (int i = 0; i < 8 * PB / 32; i++) begin
            v[32*i +: 32] = i * 32'h9E3779B9 + 32'h12345677;
        end
        return v;
    endfunction
    localparam logic [8*PB-1:0] PINIT = mk_init();

    logic mclk, rst_n, tck, tap_rst_n, cap, shift, upd, tdi, tdo;
    logic addr_step, sram_wr_ready, sram_wr_valid;
    logic [2:0] core_rd_addr, core_page_addr;
    logic [PB-1:0] core_rd_data, din, dout;
    logic [9:0] sram_wr_addr;
    logic [31:0] sram_wr_data, seed, r;
    logic [WW-1:0] w, q[$];
    int error_cnt, num_checks, cyc, cnt, prev;

    rpj_readback #(.ADDR_FROM_TDI(1'b1), .PAGE_INIT(PINIT)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .tck(tck), .tap_rst_n(tap_rst_n),
        .user_dr_capture_state(cap), .user_dr_shift_state(shift),
        .user_dr_update_state(upd), .tdi(tdi), .tdo(tdo),
        .core_rd_addr(core_rd_addr), .core_rd_data(core_rd_data),
        .addr_step(addr_step), .core_page_addr(core_page_addr),
        .sram_wr_valid(sram_wr_valid), .sram_wr_ready(sram_wr_ready),
        .sram_wr_addr(sram_wr_addr), .sram_wr_data(sram_wr_data));

    rpj_tester u_tester (.tck(tck), .tap_rst_n(tap_rst_n), .cap(cap),
        .shift(shift), .upd(upd), .tdi(tdi), .tdo(tdo));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk_page(string n, logic [PB-1:0] e, logic [PB-1:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_word(string n, logic [WW-1:0] e, logic [WW-1:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
        if (rst_n === 1'b1 && sram_wr_valid === 1'b1
            && sram_wr_ready === 1'b1) begin
            w = (q.size() > 0) ? q.pop_front() : 'x;
            chk_word("sram word", w, {sram_wr_addr, sram_wr_data});
        end
    end

    initial begin
        seed = 32'hAD8F283A;
        rst_n = 1'b0;
        core_rd_addr = 3'h0;
        addr_step = 1'b0;
        sram_wr_ready = 1'b0;
        u_tester.reset_tap();
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        // core reads alongside address counter steps
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            r = $random(seed);
            core_rd_addr <= r[2:0];
            addr_step <= r[3];
            @(posedge mclk);
            addr_step <= 1'b0;
            cnt += r[3];
            #1;
            chk_page("core page", PINIT[PB*r[2:0] +: PB],
                core_rd_data);
            chk_word("core addr", WW'(cnt % 8), WW'(core_page_addr));
        end
        // page address frames, readback of the previous one
        prev = 0;
        for (int i = 0; i <= 8; i++) begin
            din = {$random(seed), $random(seed), $random(seed), $random(seed)};
            din[127:124] = rpj_pkg::OP_PAGE_ADDR;
            din[2:0] = 3'(i % 8);
            u_tester.frame(din, i % 3, dout);
            chk_page("tdo page", PINIT[PB*prev +: PB],
                dout);
            prev = i % 8;
        end
        // fresh resets, then the sram image is loaded for the first time
        @(posedge mclk);
        rst_n <= 1'b0;
        u_tester.reset_tap();
        @(posedge mclk);
        #1;
        chk_word("addr in reset", WW'(0), WW'(core_page_addr));
        @(posedge mclk);
        rst_n <= 1'b1;
        // sram words with the sink stalled, one beyond depth
        for (int i = 0; i < 9; i++) begin
            din = {$random(seed), $random(seed), $random(seed), $random(seed)};
            din[127:124] = rpj_pkg::OP_SRAM_WR;
            q.push_back(din[WW-1:0]);
            u_tester.frame(din, 0, dout);
        end
        chk_word("sram valid full", WW'(1), WW'(sram_wr_valid));
        for (int i = 0; i < 400 && q.size() > 0; i++) begin
            @(posedge mclk);
            r = $random(seed);
            sram_wr_ready <= r[0];
        end
        @(posedge mclk);
        sram_wr_ready <= 1'b0;
        repeat (4) @(posedge mclk);
        chk_word("sram left", WW'(0), WW'(q.size()));
        chk_word("sram valid empty", WW'(0), WW'(sram_wr_valid));
        wrap_up();
    end
endmodule
